// ==== jtag_config_port.sv ====
// Serial configuration port: test access port with instruction and data registers,
// configuration and signature storage, and the readout lock fuse.
// Assumes pins arrive asynchronously; the test clock is sampled by sys_clk at 100 MHz.
`timescale 1ns/1ps

`include "jtag_prog_params.svh"

module jtag_config_port #(
	parameter int CFG_W = `CFG_W,
	parameter logic [`ID_W-1:0] ID_VALUE = 32'h00000001 // Arbitrary value, lsb set as required.
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire jtag_prog_pkg::jtag_pins_s pins,
	output logic tdo,
	output logic tdoOe,
	output logic readoutLocked,
	output logic programMode
);
	import jtag_prog_pkg::*;

	// ********************************************************
	// Pin synchronisers and edge detection
	// ********************************************************
	jtag_pins_s pinsMeta;
	jtag_pins_s pinsSync;
	logic tckPrev;
	logic tckRise;
	logic tckFall;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			// Reset high: a test clock resting high at release gives no false rise,
			// while a false fall only reloads an unchanged serial output.
			pinsMeta <= '1;
			pinsSync <= '1;
			tckPrev <= 1'b1;
		end else if (ce) begin
			pinsMeta <= pins;
			pinsSync <= pinsMeta;
			tckPrev <= pinsSync.tck;
		end
	end

	assign tckRise = ce && pinsSync.tck && !tckPrev;
	assign tckFall = ce && !pinsSync.tck && tckPrev;

	tap_state_e state;

	tap_controller u_tap (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.ce(ce),
		.step(tckRise),
		.tms(pinsSync.tms),
		.state(state)
	);

	// ********************************************************
	// Instruction register and register selection
	// ********************************************************
	logic [`IR_W-1:0] irShift;
	logic [`IR_W-1:0] instr;
	logic execArmed;

	function automatic dr_sel_e selectOf(input logic [`IR_W-1:0] op);
		case (op)
			`OP_IDCODE: selectOf = SEL_ID;
			`OP_SIG_READ, `OP_SIG_PROGRAM: selectOf = SEL_SIG;
			`OP_PLD_DATA_SHIFT, `OP_PLD_PROGRAM, `OP_PLD_VERIFY: selectOf = SEL_CFG;
			// Sample/preload, extest, bypass and unknown codes all fall to bypass.
			default: selectOf = SEL_BYPASS;
		endcase
	endfunction : selectOf

	dr_sel_e sel;
	assign sel = selectOf(instr);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irShift <= `OP_IDCODE;
			instr <= `OP_IDCODE;
			execArmed <= 1'b0;
		end else if (tckRise) begin
			case (state)
				TEST_LOGIC_RESET: begin
					instr <= `OP_IDCODE;
					execArmed <= 1'b0;
				end
				CAPTURE_IR: irShift <= `OP_IDCODE;
				SHIFT_IR: irShift <= {pinsSync.tdi, irShift[`IR_W-1:1]};
				UPDATE_IR: begin
					instr <= irShift;
					execArmed <= 1'b1;
				end
				RUN_IDLE: execArmed <= 1'b0;
				default: begin
				end
			endcase
		end
	end

	// Programming operations run on the first rise spent in run-test/idle after update.
	logic execNow;
	assign execNow = tckRise && state == RUN_IDLE && execArmed;

	// ********************************************************
	// Data shift registers
	// ********************************************************
	logic bypassBit;
	logic [`SIG_W-1:0] sigShift;
	logic [CFG_W-1:0] cfgShift;
	logic [CFG_W-1:0] nvCfg;
	logic [`SIG_W-1:0] nvSig;
	logic lockFuse;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bypassBit <= 1'b0;
			sigShift <= '0;
			cfgShift <= '0;
		end else if (tckRise) begin
			if (state == CAPTURE_DR) begin
				bypassBit <= 1'b0;
				if (sel == SEL_ID) begin
					sigShift <= ID_VALUE;
				end else if (sel == SEL_SIG) begin
					sigShift <= nvSig;
				end
				if (instr == `OP_PLD_VERIFY) begin
					cfgShift <= lockFuse ? '0 : nvCfg;
				end
			end else if (state == SHIFT_DR) begin
				case (sel)
					SEL_BYPASS: bypassBit <= pinsSync.tdi;
					SEL_ID, SEL_SIG: sigShift <= {pinsSync.tdi, sigShift[`SIG_W-1:1]};
					SEL_CFG: cfgShift <= {pinsSync.tdi, cfgShift[CFG_W-1:1]};
					default: bypassBit <= pinsSync.tdi;
				endcase
			end
		end
	end

	// ********************************************************
	// Retained storage and program operations
	// ********************************************************
	// These cells model non-volatile memory, so the port reset leaves them alone.
	always_ff @(posedge sys_clk) begin
		if (execNow && programMode) begin
			case (instr)
				`OP_BULK_ERASE: begin
					nvCfg <= '0;
					nvSig <= '0;
					lockFuse <= 1'b0;
				end
				`OP_PLD_PROGRAM: nvCfg <= cfgShift;
				`OP_SIG_PROGRAM: nvSig <= sigShift;
				`OP_PROGRAM_SECURITY: lockFuse <= 1'b1;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			programMode <= 1'b0;
		end else if (execNow) begin
			if (instr == `OP_PROGRAM_ENABLE) begin
				programMode <= 1'b1;
			end else if (instr == `OP_PROGRAM_DISABLE) begin
				programMode <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			readoutLocked <= 1'b0;
		end else if (ce) begin
			readoutLocked <= lockFuse === 1'b1;
		end
	end

	// ********************************************************
	// Serial output, changed on the falling test clock edge
	// ********************************************************
	logic drOut;

	always_comb begin
		case (sel)
			SEL_ID, SEL_SIG: drOut = sigShift[0];
			SEL_CFG: drOut = cfgShift[0];
			default: drOut = bypassBit;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			tdo <= 1'b0;
			tdoOe <= 1'b0;
		end else if (tckFall) begin
			tdoOe <= state == SHIFT_DR || state == SHIFT_IR;
			tdo <= (state == SHIFT_IR) ? irShift[0] : drOut;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	sequence s_programRun;
		execNow && programMode && instr == `OP_PLD_PROGRAM;
	endsequence

	sequence s_eraseRun;
		execNow && programMode && instr == `OP_BULK_ERASE;
	endsequence

	a_tdo_on_fall: assert property (@(posedge sys_clk) disable iff (!rstn)
		$changed(tdo) |-> $past(tckFall))
		else $error("Serial output changed away from a falling test clock.");

	a_ir_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
		tckRise && state == CAPTURE_IR |=> irShift == `OP_IDCODE)
		else $error("Instruction capture did not load the identification code.");

	a_sample_bypass: assert property (@(posedge sys_clk) disable iff (!rstn)
		instr == `OP_SAMPLE_PRELOAD |-> sel == SEL_BYPASS)
		else $error("Sample/preload did not select bypass.");

	a_bypass_path: assert property (@(posedge sys_clk) disable iff (!rstn)
		tckRise && state == SHIFT_DR && sel == SEL_BYPASS |=> bypassBit == $past(pinsSync.tdi))
		else $error("Bypass bit did not take the serial input.");

	a_lock_readout: assert property (@(posedge sys_clk) disable iff (!rstn)
		tckRise && state == CAPTURE_DR && instr == `OP_PLD_VERIFY && lockFuse |=> cfgShift == '0)
		else $error("Configuration read back while the lock fuse is set.");

	a_fuse_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(lockFuse) |-> $past(execNow && programMode && instr == `OP_BULK_ERASE))
		else $error("Lock fuse cleared by something other than bulk erase.");

	a_program_write: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_programRun |=> nvCfg == $past(cfgShift))
		else $error("Program did not transfer shifted configuration.");

	a_erase_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_eraseRun |=> nvCfg == '0 && nvSig == '0 ##1 readoutLocked == 1'b0)
		else $error("Bulk erase left stored configuration behind.");

	a_sig_read: assert property (@(posedge sys_clk) disable iff (!rstn)
		tckRise && state == CAPTURE_DR && instr == `OP_SIG_READ |=> sigShift == nvSig)
		else $error("Signature read did not capture the stored signature.");

endmodule : jtag_config_port

// ==== jtag_host_model.sv ====
// Programmer model for the serial configuration port: drives test clock, mode and data in.
// Assumes sys_clk at 100 MHz; one test clock period is eight sys_clk cycles (80 ns).
`timescale 1ns/1ps

module jtag_host_model (
	input wire logic sys_clk,
	input wire logic tdo,
	input wire logic tdoOe,
	output jtag_prog_pkg::jtag_pins_s pins
);
	import jtag_prog_pkg::*;
	// A released data-out line floats to its pull-up level.
	logic tdoLine;
	assign tdoLine = tdoOe ? tdo : 1'b1;
	// ****************************************
	// Pin stepping
	// ****************************************
	initial begin
		pins = '0;
	end
	// The test clock stands still between steps; inputs change only while it is low.
	task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
		pins.tck = 1'b0;
		pins.tms = tmsV;
		pins.tdi = tdiV;
		repeat (4) @(negedge sys_clk);
		tdoV = tdoLine;
		pins.tck = 1'b1;
		repeat (4) @(negedge sys_clk);
	endtask : step
	// Outside shifts the data line toggles so a stale level never looks valid.
	task automatic walk(input logic [7:0] path, input int n);
		logic d;
		for (int i = 0; i < n; i++) begin
			step(path[i], ~pins.tdi, d);
		end
	endtask : walk
	task automatic idle(input int n);
		walk(8'h00, n);
	endtask : idle
	task automatic tlr_reset();
		walk(8'h1f, 5);
		walk(8'h00, 1);
	endtask : tlr_reset
	task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], dout[i]);
		end
		walk(8'h01, 2);
	endtask : shift
	task automatic shift_ir(input logic [7:0] code, output logic [7:0] cap);
		logic [127:0] o;
		walk(8'h03, 4);
		shift(8, {120'h0, code}, o);
		cap = o[7:0];
	endtask : shift_ir
	task automatic shift_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
		walk(8'h01, 3);
		shift(n, din, dout);
	endtask : shift_dr
endmodule : jtag_host_model

// ==== jtag_prog_params.svh ====
// Constants of the serial configuration port: instruction codes, widths and limits.
// Assumes it is included by bare name into packages or modules that need them.
`ifndef JTAG_PROG_PARAMS_SVH
`define JTAG_PROG_PARAMS_SVH

`define IR_W 8
`define SIG_W 32
`define ID_W 32
`define CFG_W 81
`define TLR_MAX_TCKS 5

`define OP_EXTEST 8'h00
`define OP_PLD_DATA_SHIFT 8'h02
`define OP_BULK_ERASE 8'h03
`define OP_PLD_PROGRAM 8'h07
`define OP_PROGRAM_SECURITY 8'h09
`define OP_PLD_VERIFY 8'h0a
`define OP_PROGRAM_ENABLE 8'h15
`define OP_IDCODE 8'h16
`define OP_SIG_READ 8'h17
`define OP_SIG_PROGRAM 8'h1a
`define OP_SAMPLE_PRELOAD 8'h1c
`define OP_PROGRAM_DISABLE 8'h1e
`define OP_BYPASS 8'hff

`endif

// ==== jtag_prog_pkg.sv ====
// Types shared by the port controller and the configuration port top.
// Assumes the params header sits in the same folder.
`include "jtag_prog_params.svh"

package jtag_prog_pkg;

	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_IDLE,
		SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
		SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
	} tap_state_e;

	typedef enum logic [1:0] {SEL_BYPASS, SEL_ID, SEL_SIG, SEL_CFG} dr_sel_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtag_pins_s;

endpackage : jtag_prog_pkg

// ==== tap_controller.sv ====
// Sixteen-state test access port controller, stepped once per test clock rise.
// Assumes step and tms come from already synchronised pin samples on sys_clk.
`timescale 1ns/1ps

`include "jtag_prog_params.svh"

module tap_controller (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic step,
	input wire logic tms,
	output jtag_prog_pkg::tap_state_e state
);
	import jtag_prog_pkg::*;

	tap_state_e next_state;
	logic [2:0] highCount;

	always_comb begin
		next_state = state;
		case (state)
			TEST_LOGIC_RESET: next_state = tms ? TEST_LOGIC_RESET : RUN_IDLE;
			RUN_IDLE: next_state = tms ? SELECT_DR : RUN_IDLE;
			SELECT_DR: next_state = tms ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: next_state = tms ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: next_state = tms ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: next_state = tms ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: next_state = tms ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: next_state = tms ? SELECT_DR : RUN_IDLE;
			SELECT_IR: next_state = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: next_state = tms ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: next_state = tms ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: next_state = tms ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: next_state = tms ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: next_state = tms ? SELECT_DR : RUN_IDLE;
			default: next_state = TEST_LOGIC_RESET;
		endcase
	end

	// Reset here stands in for power-on, so the controller starts in test-logic-reset.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state <= TEST_LOGIC_RESET;
		end else if (ce && step) begin
			state <= next_state;
		end
	end

	// Helper count of consecutive rises with mode select high.
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			highCount <= 3'h0;
		end else if (ce && step) begin
			if (!tms) begin
				highCount <= 3'h0;
			end else if (highCount != 3'h7) begin
				highCount <= highCount + 3'h1;
			end
		end
	end

	a_tms_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
		highCount >= 3'(`TLR_MAX_TCKS) |-> state == TEST_LOGIC_RESET)
		else $error("Mode select held high without reaching test-logic-reset.");

	a_step_only: assert property (@(posedge sys_clk) disable iff (!rstn)
		!$past(step) |-> $stable(state))
		else $error("Controller state moved without a test clock rise.");

endmodule : tap_controller

// ==== tb_top.sv ====
// Self-checking bench for the serial configuration port with a programmer model.
// Assumes the package, the params header and the host model are compiled first.
`timescale 1ns/1ps

module tb_top;
	import jtag_prog_pkg::*;
	localparam logic [31:0] ID_TB = 32'h00000c35; // Arbitrary identity value, lsb set.
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	jtag_pins_s pins;
	logic tdo, tdoOe, readoutLocked, programMode;
	int err_total = 0;
	int num_checks = 0;
	logic [80:0] expCfg, cfgShift;
	logic [31:0] expSig, sigShift;
	logic expLock, expMode;
	logic [7:0] cap;
	logic [127:0] dout, din;
	logic [7:0] byCodes [4] = '{8'hff, 8'h00, 8'h1c, 8'h5a};
	always #5 sys_clk = ~sys_clk;
	jtag_config_port #(.ID_VALUE(ID_TB)) jtag_config_port_i (.sys_clk(sys_clk), .rstn(rstn),
		.ce(ce), .pins(pins), .tdo(tdo), .tdoOe(tdoOe), .readoutLocked(readoutLocked),
		.programMode(programMode));
	jtag_host_model jtag_host_model_i (.sys_clk(sys_clk), .tdo(tdo), .tdoOe(tdoOe),
		.pins(pins));
	// ****************************************
	// Checking and reference model
	// ****************************************
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d, errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task automatic load_ir(input logic [7:0] code);
		jtag_host_model_i.shift_ir(code, cap);
		check("ir capture", cap, 8'h16);
	endtask : load_ir
	task automatic xfer(input logic [7:0] code, input int n, input logic [127:0] d);
		load_ir(code);
		jtag_host_model_i.shift_dr(n, d, dout);
	endtask : xfer
	// Storage operations only take effect while program mode is on.
	task automatic run_op(input logic [7:0] code);
		load_ir(code);
		jtag_host_model_i.idle(1);
		if (expMode && code == 8'h03) begin
			expCfg = '0;
			expSig = '0;
			expLock = 1'b0;
		end
		if (expMode && code == 8'h09) expLock = 1'b1;
		if (expMode && code == 8'h07) expCfg = cfgShift;
		if (expMode && code == 8'h1a) expSig = sigShift;
		if (code == 8'h15) expMode = 1'b1;
		if (code == 8'h1e) expMode = 1'b0;
		@(negedge sys_clk);
		check("program mode", programMode, expMode);
		if (!$isunknown(expLock)) check("lock", readoutLocked, expLock);
	endtask : run_op
	task automatic verify_cfg(input logic [80:0] exp);
		xfer(8'h0a, 81, '0);
		check("config readout", dout[80:0], exp);
	endtask : verify_cfg
	task automatic read_sig();
		xfer(8'h17, 32, '0);
		check("signature", dout[31:0], expSig);
	endtask : read_sig
	task automatic pulse_reset();
		rstn = 1'b0;
		repeat (4) @(negedge sys_clk);
		rstn = 1'b1;
		expMode = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("idle out enable", tdoOe, 1'b0);
		check("mode after reset", programMode, 1'b0);
		jtag_host_model_i.idle(1);
	endtask : pulse_reset
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		#500us;
		err_total++;
		stop_test();
	end
	initial begin
		void'($urandom(32'h2b4c));
		expLock = 1'bx;
		pulse_reset();
		jtag_host_model_i.shift_dr(32, '0, dout);
		check("default id", dout[31:0], ID_TB);
		// With the clock enable low a whole test clock step must pass unseen.
		ce = 1'b0;
		jtag_host_model_i.walk(8'h01, 1);
		ce = 1'b1;
		jtag_host_model_i.shift_dr(32, '0, dout);
		check("id after frozen step", dout[31:0], ID_TB);
		foreach (byCodes[k]) begin
			din = {96'h0, $urandom};
			xfer(byCodes[k], 8, din);
			check("bypass", dout[7:0], {din[6:0], 1'b0});
		end
		run_op(8'h15);
		run_op(8'h03);
		din = {32'h0, $urandom, $urandom, $urandom};
		cfgShift = din[80:0];
		xfer(8'h02, 81, din);
		run_op(8'h07);
		verify_cfg(expCfg);
		sigShift = $urandom;
		xfer(8'h1a, 32, {96'h0, sigShift});
		run_op(8'h1a);
		read_sig();
		pulse_reset();
		run_op(8'h15);
		verify_cfg(expCfg);
		run_op(8'h09);
		verify_cfg('0);
		read_sig();
		run_op(8'h1e);
		run_op(8'h03);
		verify_cfg('0);
		run_op(8'h15);
		run_op(8'h03);
		verify_cfg('0);
		read_sig();
		load_ir(8'h17);
		jtag_host_model_i.walk(8'h00, 3);
		jtag_host_model_i.walk(8'h01, 3);
		jtag_host_model_i.walk(8'h00, 2);
		check("shift out enable", tdoOe, 1'b1);
		jtag_host_model_i.tlr_reset();
		check("out enable after tms reset", tdoOe, 1'b0);
		jtag_host_model_i.shift_dr(32, '0, dout);
		check("id after tms reset", dout[31:0], ID_TB);
		stop_test();
	end
endmodule : tb_top
